// ---- aoc_pkg.sv ----
package aoc_pkg;

	// Register addresses on the serial control port.
	localparam logic [12:0] ADDR_CLK_COND = 13'h0009;
	localparam logic [12:0] ADDR_TEST_SEL = 13'h000D;
	localparam logic [12:0] ADDR_OUT_FMT  = 13'h0014;

	// Reset values, and the value read from unmapped addresses.
	localparam logic [7:0] RST_CLK_COND = 8'h01;
	localparam logic [7:0] RST_TEST_SEL = 8'h00;
	localparam logic [7:0] RST_OUT_FMT  = 8'h00;
	localparam logic [7:0] RD_UNMAPPED  = 8'h00;

	// Field positions.
	localparam int DCS_BIT    = 0;
	localparam int TMODE_MSB  = 7;
	localparam int TMODE_LSB  = 6;
	localparam int TPAT_MSB   = 3;
	localparam int TPAT_LSB   = 0;
	localparam int LP_BIT     = 6;
	localparam int INV_BIT    = 2;
	localparam int FMT_MSB    = 1;
	localparam int FMT_LSB    = 0;

	// Field encodings.
	localparam logic [1:0] FMT_OFFSET_BIN = 2'h0;
	localparam logic [1:0] FMT_TWOS_COMP  = 2'h1;
	localparam logic [1:0] TM_CODE_OFF    = 2'h0;
	localparam logic [1:0] TM_CODE_SALT   = 2'h1;
	localparam logic [1:0] TM_CODE_SONCE  = 2'h2;
	localparam logic [1:0] TM_CODE_AONCE  = 2'h3;

	// Built-in pattern selections and their values, and the sign flip mask for twos complement.
	localparam logic [3:0] PAT_MIDSCALE = 4'h1;
	localparam logic [3:0] PAT_POS_FS   = 4'h2;
	localparam logic [3:0] PAT_NEG_FS   = 4'h3;
	localparam logic [3:0] PAT_CHECKER  = 4'h4;
	localparam logic [7:0] VAL_MIDSCALE = 8'h80;
	localparam logic [7:0] VAL_POS_FS   = 8'hFF;
	localparam logic [7:0] VAL_NEG_FS   = 8'h00;
	localparam logic [7:0] VAL_CHECKER  = 8'hAA;
	localparam logic [7:0] SIGN_FLIP    = 8'h80;

	// Serial frame layout: 16 instruction bits, then 8 data bits.
	localparam logic [4:0] INSTR_LAST = 5'h0F;
	localparam logic [4:0] DATA_LAST  = 5'h07;
	localparam logic [4:0] CNT_ONE    = 5'h01;
	localparam int         RW_BIT     = 15;

	typedef enum logic [1:0] {
		SP_IDLE,
		SP_INSTR,
		SP_DATA,
		SP_DONE
	} aoc_spi_state_t;

endpackage

// ---- aoc_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module aoc_pin_sync
	import aoc_pkg::*;
(
	// Clock and reset.
	input  wire logic clk,
	input  wire logic resetn,
	// Pin and its settled level.
	input  wire logic pin,
	input  wire logic rst_val,
	output var  logic level_ff
);

	logic s1_ff, s2_ff, s3_ff;
	logic nxt_level;

	// The level only moves once the last two stages agree, filtering glitches.
	always_comb begin
		nxt_level = (s2_ff == s3_ff) ? s3_ff : level_ff;
	end

	// The first stage is read by the second stage alone. Reset loads the
	// idle level of the pin, so no false edge follows reset.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			s1_ff    <= rst_val;
			s2_ff    <= rst_val;
			s3_ff    <= rst_val;
			level_ff <= rst_val;
		end else begin
			s1_ff    <= pin;
			s2_ff    <= s1_ff;
			s3_ff    <= s2_ff;
			level_ff <= nxt_level;
		end
	end

endmodule
`default_nettype wire

// ---- aoc_regs.sv ----
// How it works
// - Bit 0 of clock register drives stabilizer enable; register resets to 0x01.
// - Two-bit test mode: 00 off, 01 single alternate, 10 single once, 11 alternate once; code holds the pattern for 00 and 10, alternates it for 01 and 11.
// - Any nonzero test register puts pattern data on outputs; resets to 0x00.
// - Output format bit 6 selects standard (0) or low power (1) LVDS.
// - Output format bit 2 set inverts output data; clear by default.
// - Format field 00 gives offset binary, 01 gives twos complement.
`timescale 1ns/1ps
`default_nettype none
module aoc_regs
	import aoc_pkg::*;
#(
	parameter int DW = 8
) (
	// Clock and reset.
	input  wire logic          clk,
	input  wire logic          resetn,
	// Serial control port pins.
	input  wire logic          sclk,
	input  wire logic          csb_n,
	input  wire logic          sdio_i,
	output var  logic          sdio_o_ff,
	output var  logic          sdio_oe_n_ff,
	// Converted samples, offset binary, one per clock.
	input  wire logic [DW-1:0] sample_in,
	output var  logic [DW-1:0] data_out_ff,
	// Analog and LVDS controls.
	output var  logic          dcs_en_ff,
	output var  logic          lvds_lp_ff,
	output var  logic          test_active_ff,
	output var  logic [1:0]    test_mode_ff
);

	logic sclk_s, csb_s, sdi_s;
	logic sclk_d_ff, nxt_sclk_d;
	logic rise, fall;

	aoc_pin_sync u_sclk (.clk(clk), .resetn(resetn), .pin(sclk),
		.rst_val(1'b0), .level_ff(sclk_s));
	// Chip select and data idle high; reset them to that level.
	aoc_pin_sync u_csb (.clk(clk), .resetn(resetn), .pin(csb_n),
		.rst_val(1'b1), .level_ff(csb_s));
	aoc_pin_sync u_sdi (.clk(clk), .resetn(resetn), .pin(sdio_i),
		.rst_val(1'b1), .level_ff(sdi_s));

	assign rise = sclk_s & ~sclk_d_ff;
	assign fall = ~sclk_s & sclk_d_ff;

	aoc_spi_state_t state_ff, nxt_state;
	logic [4:0]  cnt_ff, nxt_cnt;
	logic [15:0] shin_ff, nxt_shin;
	logic [7:0]  shout_ff, nxt_shout;
	logic        nxt_sdo, nxt_oe_n;
	logic [7:0]  clk_reg_ff, nxt_clk_reg;
	logic [7:0]  test_reg_ff, nxt_test_reg;
	logic [7:0]  fmt_reg_ff, nxt_fmt_reg;
	logic [7:0]  rd_data;
	logic        wr_en;
	logic [12:0] wr_addr;
	logic [7:0]  wr_data;

	// Read mux; unmapped addresses answer with zero. It looks at the
	// next shift value, since the last address bit arrives on the
	// same edge on which the read byte is loaded.
	always_comb begin
		case (nxt_shin[12:0])
			ADDR_CLK_COND: rd_data = clk_reg_ff;
			ADDR_TEST_SEL: rd_data = test_reg_ff;
			ADDR_OUT_FMT:  rd_data = fmt_reg_ff;
			default:       rd_data = RD_UNMAPPED;
		endcase
	end

	// Serial port: bits are taken on rising clock edges, read data
	// leaves on falling edges. One data byte per frame; extra bits are
	// ignored until the chip select goes high again.
	always_comb begin
		nxt_state    = state_ff;
		nxt_cnt      = cnt_ff;
		nxt_shin     = shin_ff;
		nxt_shout    = shout_ff;
		nxt_sdo      = sdio_o_ff;
		nxt_oe_n     = sdio_oe_n_ff;
		nxt_sclk_d   = sclk_s;
		wr_en        = 1'b0;
		wr_addr      = shin_ff[12:0];
		wr_data      = {shout_ff[6:0], sdi_s};
		if (csb_s) begin
			nxt_state = SP_IDLE;
			nxt_cnt   = 5'h00;
			nxt_oe_n  = 1'b1;
		end else begin
			case (state_ff)
				SP_IDLE: begin
					nxt_state = SP_INSTR;
					nxt_cnt   = 5'h00;
				end
				SP_INSTR: begin
					if (rise) begin
						nxt_shin = {shin_ff[14:0], sdi_s};
						nxt_cnt  = cnt_ff + CNT_ONE;
						if (cnt_ff == INSTR_LAST) begin
							nxt_state = SP_DATA;
							nxt_cnt   = 5'h00;
						end
					end
				end
				SP_DATA: begin
					if (shin_ff[RW_BIT]) begin
						// Read: the first data bit goes out on the
						// falling edge that ends the instruction.
						if (fall) begin
							nxt_sdo   = shout_ff[7];
							nxt_oe_n  = 1'b0;
							nxt_shout = {shout_ff[6:0], 1'b0};
						end
						if (rise) begin
							nxt_cnt = cnt_ff + CNT_ONE;
							if (cnt_ff == DATA_LAST)
								nxt_state = SP_DONE;
						end
					end else if (rise) begin
						// Write data shifts apart from the
						// instruction so the address stays intact.
						nxt_shout = {shout_ff[6:0], sdi_s};
						nxt_cnt   = cnt_ff + CNT_ONE;
						if (cnt_ff == DATA_LAST) begin
							wr_en     = 1'b1;
							nxt_state = SP_DONE;
						end
					end
				end
				SP_DONE: begin
					if (fall)
						nxt_oe_n = 1'b1;
				end
				default: nxt_state = SP_IDLE;
			endcase
		end
		// Load read data as soon as the address is known.
		if (state_ff == SP_INSTR && nxt_state == SP_DATA)
			nxt_shout = rd_data;
	end

	// Register writes.
	always_comb begin
		nxt_clk_reg  = clk_reg_ff;
		nxt_test_reg = test_reg_ff;
		nxt_fmt_reg  = fmt_reg_ff;
		if (wr_en) begin
			case (wr_addr)
				ADDR_CLK_COND: nxt_clk_reg  = wr_data;
				ADDR_TEST_SEL: nxt_test_reg = wr_data;
				ADDR_OUT_FMT:  nxt_fmt_reg  = wr_data;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_ff     <= SP_IDLE;
			cnt_ff       <= 5'h00;
			shin_ff      <= 16'h0000;
			shout_ff     <= 8'h00;
			sdio_o_ff    <= 1'b0;
			sdio_oe_n_ff <= 1'b1;
			sclk_d_ff    <= 1'b0;
			clk_reg_ff   <= RST_CLK_COND;
			test_reg_ff  <= RST_TEST_SEL;
			fmt_reg_ff   <= RST_OUT_FMT;
		end else begin
			state_ff     <= nxt_state;
			cnt_ff       <= nxt_cnt;
			shin_ff      <= nxt_shin;
			shout_ff     <= nxt_shout;
			sdio_o_ff    <= nxt_sdo;
			sdio_oe_n_ff <= nxt_oe_n;
			sclk_d_ff    <= nxt_sclk_d;
			clk_reg_ff   <= nxt_clk_reg;
			test_reg_ff  <= nxt_test_reg;
			fmt_reg_ff   <= nxt_fmt_reg;
		end
	end

	// Data path. Alternating modes swap the pattern with its complement
	// every sample so a receiver can check every bit in both states.
	logic          alt_ff, nxt_alt;
	logic [DW-1:0] pattern, formatted, nxt_data;
	logic          nxt_dcs, nxt_lp, nxt_test;
	logic [1:0]    nxt_tmode;
	logic [1:0]    tmode;

	always_comb begin
		tmode = test_reg_ff[TMODE_MSB:TMODE_LSB];
		nxt_tmode = tmode;
		nxt_alt = ~alt_ff;
		case (test_reg_ff[TPAT_MSB:TPAT_LSB])
			PAT_POS_FS:  pattern = VAL_POS_FS;
			PAT_NEG_FS:  pattern = VAL_NEG_FS;
			PAT_CHECKER: pattern = VAL_CHECKER;
			default:     pattern = VAL_MIDSCALE;
		endcase
		if ((tmode == TM_CODE_SALT || tmode == TM_CODE_AONCE) && alt_ff)
			pattern = ~pattern;
		formatted = sample_in;
		if (fmt_reg_ff[FMT_MSB:FMT_LSB] == FMT_TWOS_COMP)
			formatted = sample_in ^ SIGN_FLIP;
		nxt_test = (test_reg_ff != RST_TEST_SEL);
		nxt_data = nxt_test ? pattern : formatted;
		if (fmt_reg_ff[INV_BIT])
			nxt_data = ~nxt_data;
		nxt_dcs = clk_reg_ff[DCS_BIT];
		nxt_lp  = fmt_reg_ff[LP_BIT];
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			alt_ff         <= 1'b0;
			data_out_ff    <= '0;
			dcs_en_ff      <= 1'b1;
			lvds_lp_ff     <= 1'b0;
			test_active_ff <= 1'b0;
			test_mode_ff   <= TM_CODE_OFF;
		end else begin
			alt_ff         <= nxt_alt;
			data_out_ff    <= nxt_data;
			dcs_en_ff      <= nxt_dcs;
			lvds_lp_ff     <= nxt_lp;
			test_active_ff <= nxt_test;
			test_mode_ff   <= nxt_tmode;
		end
	end

	// Checks.
	sequence s_fmt_write;
		wr_en && wr_addr == ADDR_OUT_FMT;
	endsequence

	a_dcs_reset: assert property (@(posedge clk) disable iff (!resetn)
		$past(!resetn) |-> dcs_en_ff && clk_reg_ff == RST_CLK_COND)
		else $error("Stabilizer not on after reset.");
	a_dcs_write: assert property (@(posedge clk) disable iff (!resetn)
		wr_en && wr_addr == ADDR_CLK_COND |=> ##1
		dcs_en_ff == $past(wr_data[DCS_BIT], 2))
		else $error("Stabilizer does not follow write.");
	a_tmode_alt: assert property (@(posedge clk) disable iff (!resetn)
		test_reg_ff[TMODE_MSB:TMODE_LSB] == TM_CODE_SALT
		&& $stable(test_reg_ff) && test_active_ff
		|=> data_out_ff == ~$past(data_out_ff))
		else $error("Alternate mode does not alternate.");
	a_test_drive: assert property (@(posedge clk) disable iff (!resetn)
		test_reg_ff[TPAT_MSB:TPAT_LSB] == PAT_POS_FS
		&& test_reg_ff[TMODE_MSB:TMODE_LSB] == TM_CODE_OFF
		&& !fmt_reg_ff[INV_BIT] |=> data_out_ff == VAL_POS_FS)
		else $error("Test pattern not on outputs.");
	a_lp_mode: assert property (@(posedge clk) disable iff (!resetn)
		$rose(fmt_reg_ff[LP_BIT]) |=> lvds_lp_ff)
		else $error("Low power LVDS not selected.");
	a_data_invert: assert property (@(posedge clk) disable iff (!resetn)
		test_reg_ff == RST_TEST_SEL && fmt_reg_ff[INV_BIT]
		&& fmt_reg_ff[FMT_MSB:FMT_LSB] == FMT_OFFSET_BIN
		|=> data_out_ff == ~$past(sample_in))
		else $error("Inverted output wrong.");
	a_twos_comp: assert property (@(posedge clk) disable iff (!resetn)
		test_reg_ff == RST_TEST_SEL && !fmt_reg_ff[INV_BIT]
		&& fmt_reg_ff[FMT_MSB:FMT_LSB] == FMT_TWOS_COMP
		|=> data_out_ff == ($past(sample_in) ^ SIGN_FLIP))
		else $error("Twos complement output wrong.");
	a_fmt_store: assert property (@(posedge clk) disable iff (!resetn)
		s_fmt_write |=> fmt_reg_ff == $past(wr_data))
		else $error("Format write lost.");

endmodule
`default_nettype wire

// ---- aoc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module aoc_host (
	// Clock.
	input  wire logic clk,
	// Device read drive.
	input  wire logic sdio_o,
	input  wire logic sdio_oe_n,
	// Serial pins.
	output var  logic sclk,
	output var  logic csb_n,
	output wire logic sdio
);
	logic host_bit;

	// A released line carries host_bit, held high through read data.
	assign sdio = !sdio_oe_n ? sdio_o : host_bit;

	// The serial clock stands low between frames.
	initial begin
		sclk = 1'b0;
		csb_n = 1'b1;
		host_bit = 1'b1;
	end

	// Eight clocks per level leaves margin over the pin synchronisers.
	task automatic hold();
		repeat (8) @(posedge clk);
		#1;
	endtask

	// One frame: 16 instruction bits, then 8 data bits, MSB first.
	task automatic xfer(input logic [15:0] ins, input logic [7:0] wd,
		output logic [7:0] rd);
		logic [23:0] fr;
		fr = {ins, wd};
		rd = 8'h00;
		@(posedge clk);
		#1;
		csb_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			host_bit = (i < 8 && ins[15]) ? 1'b1 : fr[i];
			hold();
			if (i < 8) rd = {rd[6:0], sdio};
			sclk = 1'b1;
			hold();
			sclk = 1'b0;
		end
		hold();
		csb_n = 1'b1;
		host_bit = 1'b1;
		hold();
	endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
	import aoc_pkg::*;
	logic       clk, resetn, sclk, csb_n, sdio_o, sdio_oe_n;
	wire logic  sdio;
	logic [7:0] sample_in, data_out, rd, a, b;
	logic       dcs_en, lvds_lp, t_act;
	logic [1:0] t_mode;
	int         fails, checked;
	logic [7:0] fmt_v[5] = '{8'h00, 8'h01, 8'h04, 8'h44, 8'h45};
	logic [7:0] fmt_e[5] = '{8'h3C, 8'hBC, 8'hC3, 8'hC3, 8'h43};
	logic [7:0] pat_e[5] = '{8'h80, 8'hFF, 8'h00, 8'hAA, 8'h80};

	aoc_regs #(.DW(8)) i_aoc_regs (.clk(clk), .resetn(resetn),
		.sclk(sclk), .csb_n(csb_n), .sdio_i(sdio), .sdio_o_ff(sdio_o),
		.sdio_oe_n_ff(sdio_oe_n), .sample_in(sample_in),
		.data_out_ff(data_out), .dcs_en_ff(dcs_en), .lvds_lp_ff(lvds_lp),
		.test_active_ff(t_act), .test_mode_ff(t_mode));

	aoc_host i_aoc_host (.clk(clk), .sdio_o(sdio_o),
		.sdio_oe_n(sdio_oe_n), .sclk(sclk), .csb_n(csb_n), .sdio(sdio));

	// Free-running 50 MHz clock.
	initial clk = 1'b0;
	always #10 clk = ~clk;

	// Compare tasks for bytes and for flags.
	task automatic chk_byte(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_bit(input string nm, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask

	// Register access over the serial port.
	task automatic wr(input logic [12:0] ad, input logic [7:0] d);
		i_aoc_host.xfer({3'b000, ad}, d, rd);
	endtask
	task automatic rd_chk(input string nm, input logic [12:0] ad,
		input logic [7:0] e);
		i_aoc_host.xfer({3'b100, ad}, 8'h00, rd);
		chk_byte(nm, e, rd);
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Single place where the run ends.
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Watchdog so a hang still reaches the report.
	initial begin
		repeat (100000) @(posedge clk);
		fails++;
		complete_run();
	end

	// Main sequence.
	initial begin
		resetn = 1'b0;
		sample_in = 8'h3C;
		fails = 0;
		checked = 0;
		step(20);
		resetn = 1'b1;
		step(3);
		chk_bit("dcs_en", 1'b1, dcs_en);
		chk_bit("lvds_lp", 1'b0, lvds_lp);
		chk_bit("test_active", 1'b0, t_act);
		chk_byte("data_out", 8'h3C, data_out);
		rd_chk("clk_cond", ADDR_CLK_COND, 8'h01);
		rd_chk("test_sel", ADDR_TEST_SEL, 8'h00);
		rd_chk("out_fmt", ADDR_OUT_FMT, 8'h00);
		rd_chk("unmapped", 13'h0001, 8'h00);
		wr(ADDR_CLK_COND, 8'h00);
		chk_bit("dcs_off", 1'b0, dcs_en);
		wr(ADDR_CLK_COND, 8'h01);
		chk_bit("dcs_on", 1'b1, dcs_en);
		// Format, inversion and swing settings on a fixed sample.
		for (int i = 0; i < 5; i++) begin
			wr(ADDR_OUT_FMT, fmt_v[i]);
			rd_chk("fmt_rd", ADDR_OUT_FMT, fmt_v[i]);
			chk_byte("fmt_out", fmt_e[i], data_out);
			chk_bit("lp", fmt_v[i][6], lvds_lp);
		end
		wr(ADDR_OUT_FMT, 8'h00);
		// Each built-in pattern, plus an unlisted code.
		for (int p = 1; p < 6; p++) begin
			wr(ADDR_TEST_SEL, {4'h0, 4'(p)});
			chk_bit("t_act", 1'b1, t_act);
			chk_byte("pat", pat_e[p-1], data_out);
		end
		// Every test mode code with the checker pattern.
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_TEST_SEL, {2'(m), 2'b00, PAT_CHECKER});
			rd_chk("tsel_rd", ADDR_TEST_SEL, {2'(m), 6'h04});
			chk_byte("t_mode", 8'(m), {6'h00, t_mode});
			a = data_out;
			step(1);
			b = data_out;
			chk_bit("pat_val", 1'b1, a === 8'hAA || a === 8'h55);
			chk_byte("pat_alt", m[0] ? 8'hFF : 8'h00, a ^ b);
		end
		// Clearing the test register returns converted samples.
		wr(ADDR_TEST_SEL, 8'h00);
		sample_in = 8'h5A;
		step(3);
		chk_bit("t_off", 1'b0, t_act);
		chk_byte("t_mode0", 8'h00, {6'h00, t_mode});
		chk_byte("sample", 8'h5A, data_out);
		complete_run();
	end
endmodule
`default_nettype wire
